/* bench/pwos_actuator_model.sv */
// Actuator load on the pulse pin: counts pulses and measures high time and period
`timescale 1ns/100ps
`default_nettype none
module pwos_actuator_model (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic pulse_in,
	output logic [31:0] rise_count_out,
	output logic [31:0] high_len_out,
	output logic [31:0] period_len_out
);
	logic prev_reg;
	logic [31:0] hi_cnt_reg;
	logic [31:0] per_cnt_reg;

	// =====================================================================
	// Edge detection and length measurement in clock cycles
	// =====================================================================
	// High time is latched on the falling edge, period on the next rise; the first period is counted from reset
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			prev_reg <= 1'b0;
			hi_cnt_reg <= 32'h00000000;
			per_cnt_reg <= 32'h00000000;
			rise_count_out <= 32'h00000000;
			high_len_out <= 32'h00000000;
			period_len_out <= 32'h00000000;
		end else begin
			prev_reg <= pulse_in;
			if (pulse_in && !prev_reg) begin
				rise_count_out <= rise_count_out + 32'h00000001;
				period_len_out <= per_cnt_reg;
				per_cnt_reg <= 32'h00000001;
			end else begin
				per_cnt_reg <= per_cnt_reg + 32'h00000001;
			end
			if (pulse_in) begin
				hi_cnt_reg <= prev_reg ? hi_cnt_reg + 32'h00000001 : 32'h00000001;
			end
			if (!pulse_in && prev_reg) begin
				high_len_out <= hi_cnt_reg;
			end
		end
	end
endmodule
`default_nettype wire

/* bench/test_pulse_width_output_status.sv */
// Self-checking bench of the pulse-width output block over its register bus
`timescale 1ns/100ps
`default_nettype none
module test_pulse_width_output_status;
	import pwos_pkg::*;
	localparam int PER [3] = '{20, 10, 4};
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic start = 1'b0;
	logic ce = 1'b1;
	pwos_avs_req_t req = '0;
	pwos_avs_rsp_t rsp0;
	pwos_avs_rsp_t rsp1;
	logic pulse0, run0, done0, ovf0, irq0, pulse1, run1, done1, ovf1, irq1;
	logic ovf1_seen = 1'b0;
	logic [31:0] rises, hi_len, per_len, rd0, rd1, base;
	int err_count = 0;
	int tests_run = 0;
	int cyc = 0;
	int n;

	// =====================================================================
	// Clock, devices under test and actuator load
	// =====================================================================
	always #4 sys_clk = ~sys_clk;
	// Counting channel; the continuous-only channel shares bus and start
	pwos_top #(.COUNT_CAPABLE(1'b1), .PERIOD_CYC0(24'h000014), .PERIOD_CYC1(24'h00000A),
		.PERIOD_CYC2(24'h000004)) pwos_top_i (.sys_clk_in(sys_clk), .resetn_in(resetn),
		.ce_in(ce), .start_pin_in(start), .avs_req_in(req), .avs_rsp_out(rsp0),
		.pulse_pin_out(pulse0), .running_out(run0), .done_out(done0),
		.overflow_out(ovf0), .irq_out(irq0));
	pwos_top #(.COUNT_CAPABLE(1'b0)) pwos_top_cont_i (.sys_clk_in(sys_clk), .resetn_in(resetn),
		.ce_in(ce), .start_pin_in(start), .avs_req_in(req), .avs_rsp_out(rsp1),
		.pulse_pin_out(pulse1), .running_out(run1), .done_out(done1),
		.overflow_out(ovf1), .irq_out(irq1));
	pwos_actuator_model pwos_actuator_model_i (.clk_in(sys_clk), .resetn_in(resetn),
		.pulse_in(pulse0), .rise_count_out(rises), .high_len_out(hi_len),
		.period_len_out(per_len));

	// =====================================================================
	// Report, timeout and monitors
	// =====================================================================
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Hang guard and sticky watch of the continuous channel's overflow
	always @(posedge sys_clk) begin
		cyc++;
		if (ovf1 === 1'b1) ovf1_seen <= 1'b1;
		if (cyc == 40000) begin
			err_count++;
			print_verdict();
		end
	end

	// =====================================================================
	// Bus and comparison tasks
	// =====================================================================
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	// One Avalon transfer; request held until waitrequest is sampled low
	task automatic bus(input logic wr_en, input logic [3:0] idx, input logic [15:0] d);
		@(posedge sys_clk);
		req.read <= !wr_en;
		req.write <= wr_en;
		req.address <= {idx, 2'h0};
		req.writedata <= {16'h0000, d};
		req.byteenable <= 4'hF;
		do @(posedge sys_clk); while (rsp0.waitrequest !== 1'b0);
		rd0 = rsp0.readdata;
		rd1 = rsp1.readdata;
		req.read <= 1'b0;
		req.write <= 1'b0;
	endtask
	task automatic rdchk(input string what, input logic [3:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 16'h0000);
		chk(what, exp, rd0);
	endtask
	task automatic cfg(input logic [15:0] f, d, c, hi, lo);
		bus(1'b1, PWOS_IDX_FREQ, f);
		bus(1'b1, PWOS_IDX_DUTY, d);
		bus(1'b1, PWOS_IDX_CNTEN, c);
		bus(1'b1, PWOS_IDX_PRE_HI, hi);
		bus(1'b1, PWOS_IDX_PRE_LO, lo);
	endtask
	// Start level change, then room for the synchroniser to pass it
	task automatic go(input logic v);
		@(posedge sys_clk);
		start <= v;
		repeat (8) @(posedge sys_clk);
	endtask
	task automatic wait_done();
		n = 0;
		while (done0 !== 1'b1 && n < 400) begin
			@(posedge sys_clk);
			n++;
		end
	endtask
	// Checks the code of a start attempt; only a clean code may run
	task automatic errchk(input logic [15:0] f, d, c, hi, lo, input logic [2:0] code);
		cfg(f, d, c, hi, lo);
		go(1'b1);
		rdchk("error_code", PWOS_IDX_ERR, {29'h0, code});
		chk("running_after_check", {31'h0, code == PWOS_ERR_NONE}, {31'h0, run0});
		go(1'b0);
	endtask

	// =====================================================================
	// Main sequence
	// =====================================================================
	initial begin
		repeat (16) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		// Idle state, read-only running flag and an unmapped place
		rdchk("running_reset", PWOS_IDX_RUN, 32'h0);
		bus(1'b1, PWOS_IDX_RUN, 16'h0001);
		rdchk("running_ro", PWOS_IDX_RUN, 32'h0);
		rdchk("unmapped", 4'hF, 32'h0);
		chk("pulse_idle", 32'h0, {31'h0, pulse0});
		bus(1'b1, PWOS_IDX_IRQ_MASK, 16'h000F);
		// Counted run of three pulses at the slowest rate
		cfg(16'h0000, 16'h0032, 16'h0001, 16'h0000, 16'h0003);
		base = rises;
		go(1'b1);
		chk("running_start", 32'h1, {31'h0, run0});
		wait_done();
		chk("running_end", 32'h0, {31'h0, run0});
		chk("pulse_count", 32'h3, rises - base);
		chk("high_len", 32'hA, hi_len);
		chk("pulse_end", 32'h0, {31'h0, pulse0});
		rdchk("done_reg", PWOS_IDX_DONE, 32'h1);
		rdchk("running_reg", PWOS_IDX_RUN, 32'h0);
		rdchk("overflow_reg", PWOS_IDX_OVF, 32'h0);
		rdchk("current_lo", PWOS_IDX_CUR_LO, 32'h3);
		rdchk("irq_status", PWOS_IDX_IRQ_ST, 32'h3);
		chk("irq_raised", 32'h1, {31'h0, irq0});
		bus(1'b1, PWOS_IDX_IRQ_ST, 16'h000F);
		rdchk("irq_cleared", PWOS_IDX_IRQ_ST, 32'h0);
		chk("irq_low", 32'h0, {31'h0, irq0});
		bus(1'b0, PWOS_IDX_ERR, 16'h0000);
		chk("cont_counting_err", {29'h0, PWOS_ERR_CONT}, rd1);
		chk("cont_no_run", 32'h0, {31'h0, run1});
		go(1'b0);
		// Continuous runs on every rate code, interrupt masked
		bus(1'b1, PWOS_IDX_IRQ_MASK, 16'h0000);
		for (int f = 0; f < 3; f++) begin
			cfg(16'(f), 16'h0032, 16'h0000, 16'h0000, 16'h0000);
			go(1'b1);
			chk("done_clear", 32'h0, {31'h0, done0});
			chk("running_cont", 32'h1, {31'h0, run1});
			repeat (3 * PER[f] + 2) @(posedge sys_clk);
			chk("period_len", 32'(PER[f]), per_len);
			chk("high_len_rate", 32'(PER[f] / 2), hi_len);
			// Clock enable low must freeze the pulse train and the flags
			if (f == 1) begin
				ce <= 1'b0;
				repeat (2) @(posedge sys_clk);
				base = rises;
				repeat (25) @(posedge sys_clk);
				chk("frozen_rises", base, rises);
				chk("frozen_running", 32'h1, {31'h0, run0});
				ce <= 1'b1;
			end
			if (f == 0) begin
				bus(1'b1, PWOS_IDX_DUTY, 16'h0019);
				repeat (60) @(posedge sys_clk);
				chk("high_len_new_duty", 32'h5, hi_len);
				chk("running_duty", 32'h1, {31'h0, run0});
			end
			go(1'b0);
			chk("running_stop", 32'h0, {31'h0, run0});
			chk("done_stop", 32'h1, {31'h0, done0});
			chk("pulse_stop", 32'h0, {31'h0, pulse0});
			chk("cont_done_stop", 32'h1, {31'h0, done1});
			chk("cont_pulse_stop", 32'h0, {31'h0, pulse1});
		end
		chk("irq_masked", 32'h0, {31'h0, irq0});
		bus(1'b1, PWOS_IDX_IRQ_MASK, 16'h000F);
		repeat (3) @(posedge sys_clk);
		chk("irq_unmasked", 32'h1, {31'h0, irq0});
		chk("cont_irq_unmasked", 32'h1, {31'h0, irq1});
		bus(1'b1, PWOS_IDX_IRQ_ST, 16'h000F);
		repeat (3) @(posedge sys_clk);
		chk("irq_cleared_again", 32'h0, {31'h0, irq0});
		// Preset lowered below the count mid-run, then a fresh start
		cfg(16'h0001, 16'h0032, 16'h0001, 16'h0000, 16'h000A);
		go(1'b1);
		repeat (45) @(posedge sys_clk);
		bus(1'b1, PWOS_IDX_PRE_LO, 16'h0002);
		wait_done();
		chk("overflow_set", 32'h1, {31'h0, ovf0});
		chk("running_ovf", 32'h0, {31'h0, run0});
		rdchk("overflow_reg_set", PWOS_IDX_OVF, 32'h1);
		go(1'b0);
		bus(1'b1, PWOS_IDX_PRE_LO, 16'h0003);
		go(1'b1);
		chk("overflow_clear", 32'h0, {31'h0, ovf0});
		chk("done_restart", 32'h0, {31'h0, done0});
		wait_done();
		go(1'b0);
		chk("cont_overflow", 32'h0, {31'h0, ovf1_seen});
		// Field checks at start, boundaries of every field
		errchk(16'h0003, 16'h0032, 16'h0000, 16'h0000, 16'h0000, PWOS_ERR_FREQ);
		errchk(16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, PWOS_ERR_DUTY);
		errchk(16'h0000, 16'h0065, 16'h0000, 16'h0000, 16'h0000, PWOS_ERR_DUTY);
		errchk(16'h0000, 16'h0064, 16'h0000, 16'h0000, 16'h0000, PWOS_ERR_NONE);
		errchk(16'h0000, 16'h0032, 16'h0002, 16'h0000, 16'h0000, PWOS_ERR_CNTEN);
		errchk(16'h0000, 16'h0032, 16'h0001, 16'h0000, 16'h0000, PWOS_ERR_PRESET);
		errchk(16'h0000, 16'h0032, 16'h0001, 16'h05F5, 16'hE101, PWOS_ERR_PRESET);
		errchk(16'h0000, 16'h0032, 16'h0001, 16'h05F5, 16'hE100, PWOS_ERR_NONE);
		print_verdict();
	end
endmodule
`default_nettype wire

/* rtl/pwos_pkg.sv */
// Constants, register map and carrier types of the pulse-width output block
package pwos_pkg;

	// =====================================================================
	// Widths and clock
	// =====================================================================
	localparam int unsigned PWOS_ADDR_W = 6;
	localparam int unsigned PWOS_DATA_W = 32;
	localparam int unsigned PWOS_PH_W = 24;
	localparam int unsigned PWOS_CNT_W = 32;
	localparam int unsigned PWOS_IRQ_W = 4;
	localparam longint unsigned PWOS_CLK_HZ = 64'd125000000;

	// =====================================================================
	// Output frequencies in units of 0.01 Hz, and period counts derived from them
	// =====================================================================
	localparam longint unsigned PWOS_FREQ0_CHZ = 64'd1144;
	localparam longint unsigned PWOS_FREQ1_CHZ = 64'd4578;
	localparam longint unsigned PWOS_FREQ2_CHZ = 64'd36620;
	localparam longint unsigned PWOS_CHZ_PER_HZ = 64'd100;
	localparam logic [23:0] PWOS_PERIOD_CYC0 = 24'((PWOS_CLK_HZ * PWOS_CHZ_PER_HZ) / PWOS_FREQ0_CHZ);
	localparam logic [23:0] PWOS_PERIOD_CYC1 = 24'((PWOS_CLK_HZ * PWOS_CHZ_PER_HZ) / PWOS_FREQ1_CHZ);
	localparam logic [23:0] PWOS_PERIOD_CYC2 = 24'((PWOS_CLK_HZ * PWOS_CHZ_PER_HZ) / PWOS_FREQ2_CHZ);

	// =====================================================================
	// Register indices; byte address is four times the index
	// =====================================================================
	localparam logic [3:0] PWOS_IDX_RUN = 4'h0;
	localparam logic [3:0] PWOS_IDX_DONE = 4'h1;
	localparam logic [3:0] PWOS_IDX_OVF = 4'h2;
	localparam logic [3:0] PWOS_IDX_FREQ = 4'h3;
	localparam logic [3:0] PWOS_IDX_DUTY = 4'h4;
	localparam logic [3:0] PWOS_IDX_CNTEN = 4'h5;
	localparam logic [3:0] PWOS_IDX_PRE_HI = 4'h6;
	localparam logic [3:0] PWOS_IDX_PRE_LO = 4'h7;
	localparam logic [3:0] PWOS_IDX_CUR_HI = 4'h8;
	localparam logic [3:0] PWOS_IDX_CUR_LO = 4'h9;
	localparam logic [3:0] PWOS_IDX_ERR = 4'hA;
	localparam logic [3:0] PWOS_IDX_IRQ_ST = 4'hB;
	localparam logic [3:0] PWOS_IDX_IRQ_MASK = 4'hC;

	// =====================================================================
	// Field limits, error codes, interrupt bits, reset values
	// =====================================================================
	localparam logic [15:0] PWOS_FCODE_MAX = 16'h0002;
	localparam logic [15:0] PWOS_DUTY_MIN = 16'h0001;
	localparam logic [15:0] PWOS_DUTY_MAX = 16'h0064;
	localparam logic [31:0] PWOS_PCT_DIV = 32'h00000064;
	localparam logic [15:0] PWOS_CNTEN_ON = 16'h0001;
	localparam logic [31:0] PWOS_PRESET_MIN = 32'h00000001;
	localparam logic [31:0] PWOS_PRESET_MAX = 32'h05F5E100;
	localparam logic [2:0] PWOS_ERR_NONE = 3'h0;
	localparam logic [2:0] PWOS_ERR_FREQ = 3'h1;
	localparam logic [2:0] PWOS_ERR_DUTY = 3'h2;
	localparam logic [2:0] PWOS_ERR_CNTEN = 3'h3;
	localparam logic [2:0] PWOS_ERR_PRESET = 3'h4;
	localparam logic [2:0] PWOS_ERR_CONT = 3'h5;
	localparam int unsigned PWOS_IRQ_START = 0;
	localparam int unsigned PWOS_IRQ_DONE = 1;
	localparam int unsigned PWOS_IRQ_OVF = 2;
	localparam int unsigned PWOS_IRQ_ERR = 3;
	localparam logic [15:0] PWOS_WORD_RST = 16'h0000;
	localparam logic [3:0] PWOS_IRQ_RST = 4'h0;

	// =====================================================================
	// Types
	// =====================================================================
	typedef enum logic {PWOS_IDLE, PWOS_RUN} pwos_fsm_t;

	typedef struct packed {
		logic read;
		logic write;
		logic [5:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} pwos_avs_req_t;

	typedef struct packed {
		logic waitrequest;
		logic [31:0] readdata;
	} pwos_avs_rsp_t;

	typedef struct packed {
		pwos_fsm_t fsm;
		logic sync1;
		logic sync2;
		logic sync3;
		logic start_lvl;
		logic counted;
		logic [23:0] period;
		logic [23:0] phase;
		logic [23:0] high_len;
		logic [31:0] count;
		logic [15:0] fcode;
		logic [15:0] duty;
		logic [15:0] cnten;
		logic [15:0] pre_hi;
		logic [15:0] pre_lo;
		logic [2:0] err;
		logic run;
		logic done;
		logic ovf;
		logic pulse;
		logic [3:0] irq_st;
		logic [3:0] irq_mask;
		logic irq;
		logic wait_req;
		logic [31:0] rdata;
	} pwos_state_t;

endpackage

/* rtl/pwos_top.sv */
// Pulse-width output generator with pulse counting, status flags and Avalon-MM registers
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Running flag is high while pulsing; drops on start low, finished count or overflow.
// - Done flag rises when a counted run finishes or pulsing is stopped.
// - Done flag clears when start is asserted.
// - Overflow flag rises when a counted run emitted more pulses than preset.
// - Overflow flag clears when start is asserted.
// - On the continuous-only variant the overflow flag stays zero.
// - Running, done, overflow read as bit 0 of three consecutive read-only words; done and overflow can both be set.
// - Start begins pulses at the coded frequency with high time from duty.
// - Counted run stops at preset, drops running and raises done.
// - Start low stops pulsing at once, drops running, raises done.
// - A rewritten duty applies from the next period without stopping.
// - Count enable one means counted run; zero means run while start high.
// - Duty 1 to 100 sets high time as that percent of period.
// - Frequency code 0 to 2 picks one of three rates, higher is faster.
// - Control words are checked at start; code 0 to 5 names first fault.
// - Preset is a 32-bit high/low word pair, valid 1 to 100,000,000.
module pwos_top #(
	parameter bit COUNT_CAPABLE = 1'b1,
	parameter logic [23:0] PERIOD_CYC0 = pwos_pkg::PWOS_PERIOD_CYC0,
	parameter logic [23:0] PERIOD_CYC1 = pwos_pkg::PWOS_PERIOD_CYC1,
	parameter logic [23:0] PERIOD_CYC2 = pwos_pkg::PWOS_PERIOD_CYC2
) (
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	input wire logic start_pin_in,
	input wire pwos_pkg::pwos_avs_req_t avs_req_in,
	output var pwos_pkg::pwos_avs_rsp_t avs_rsp_out,
	output logic pulse_pin_out,
	output logic running_out,
	output logic done_out,
	output logic overflow_out,
	output logic irq_out
);
	import pwos_pkg::*;

	pwos_state_t st_reg;
	pwos_state_t st_next;
	logic start_new;
	logic start_rise;
	logic start_fall;
	logic [31:0] preset;
	logic [23:0] period_sel;
	logic [2:0] err_code;
	logic phase_end;
	logic [31:0] cnt_inc;
	logic [3:0] rd_idx;
	logic [31:0] rd_mux;
	logic bus_done;

	// =====================================================================
	// Helpers
	// =====================================================================
	// High time for a period; duty above 100 is clamped so a bad rewrite stays bounded
	function automatic logic [23:0] high_of(input logic [23:0] per, input logic [15:0] duty);
		logic [6:0] d;
		logic [31:0] prod;
		d = (duty > PWOS_DUTY_MAX) ? PWOS_DUTY_MAX[6:0] : duty[6:0];
		prod = 32'(per) * 32'(d);
		return 24'(prod / PWOS_PCT_DIV);
	endfunction

	// Byte-lane merge of a 16-bit word
	function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [15:0] r;
		r = old;
		if (be[0]) begin
			r[7:0] = wd[7:0];
		end
		if (be[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction

	// =====================================================================
	// Start synchroniser and edges
	// =====================================================================
	// Level is accepted once the second and third stages agree
	assign start_new = (st_reg.sync2 == st_reg.sync3) ? st_reg.sync3 : st_reg.start_lvl;
	assign start_rise = start_new & ~st_reg.start_lvl;
	assign start_fall = ~start_new & st_reg.start_lvl;

	// =====================================================================
	// Control word decode and validation
	// =====================================================================
	assign preset = {st_reg.pre_hi, st_reg.pre_lo};
	assign phase_end = (st_reg.phase == (st_reg.period - 24'h000001));
	assign cnt_inc = st_reg.count + 32'h00000001;
	assign rd_idx = avs_req_in.address[5:2];
	assign bus_done = (avs_req_in.read | avs_req_in.write) & ~st_reg.wait_req;

	// Frequency code picks the period, higher code shorter period
	always_comb begin
		if (st_reg.fcode == 16'h0002) begin
			period_sel = PERIOD_CYC2;
		end else if (st_reg.fcode == 16'h0001) begin
			period_sel = PERIOD_CYC1;
		end else begin
			period_sel = PERIOD_CYC0;
		end
	end

	// First faulty field wins
	always_comb begin
		if (st_reg.fcode > PWOS_FCODE_MAX) begin
			err_code = PWOS_ERR_FREQ;
		end else if (st_reg.duty < PWOS_DUTY_MIN || st_reg.duty > PWOS_DUTY_MAX) begin
			err_code = PWOS_ERR_DUTY;
		end else if (st_reg.cnten > PWOS_CNTEN_ON) begin
			err_code = PWOS_ERR_CNTEN;
		end else if (!COUNT_CAPABLE && st_reg.cnten == PWOS_CNTEN_ON) begin
			err_code = PWOS_ERR_CONT;
		end else if (st_reg.cnten == PWOS_CNTEN_ON &&
			(preset < PWOS_PRESET_MIN || preset > PWOS_PRESET_MAX)) begin
			err_code = PWOS_ERR_PRESET;
		end else begin
			err_code = PWOS_ERR_NONE;
		end
	end

	// =====================================================================
	// Register read decode
	// =====================================================================
	// Flags sit in bit 0 of three consecutive words, unmapped reads give zero
	always_comb begin
		if (rd_idx == PWOS_IDX_RUN) begin
			rd_mux = {31'h00000000, st_reg.run};
		end else if (rd_idx == PWOS_IDX_DONE) begin
			rd_mux = {31'h00000000, st_reg.done};
		end else if (rd_idx == PWOS_IDX_OVF) begin
			rd_mux = {31'h00000000, st_reg.ovf};
		end else if (rd_idx == PWOS_IDX_FREQ) begin
			rd_mux = {16'h0000, st_reg.fcode};
		end else if (rd_idx == PWOS_IDX_DUTY) begin
			rd_mux = {16'h0000, st_reg.duty};
		end else if (rd_idx == PWOS_IDX_CNTEN) begin
			rd_mux = {16'h0000, st_reg.cnten};
		end else if (rd_idx == PWOS_IDX_PRE_HI) begin
			rd_mux = {16'h0000, st_reg.pre_hi};
		end else if (rd_idx == PWOS_IDX_PRE_LO) begin
			rd_mux = {16'h0000, st_reg.pre_lo};
		end else if (rd_idx == PWOS_IDX_CUR_HI) begin
			rd_mux = {16'h0000, st_reg.count[31:16]};
		end else if (rd_idx == PWOS_IDX_CUR_LO) begin
			rd_mux = {16'h0000, st_reg.count[15:0]};
		end else if (rd_idx == PWOS_IDX_ERR) begin
			rd_mux = {29'h00000000, st_reg.err};
		end else if (rd_idx == PWOS_IDX_IRQ_ST) begin
			rd_mux = {28'h0000000, st_reg.irq_st};
		end else if (rd_idx == PWOS_IDX_IRQ_MASK) begin
			rd_mux = {28'h0000000, st_reg.irq_mask};
		end else begin
			rd_mux = 32'h00000000;
		end
	end

	// =====================================================================
	// Next state
	// =====================================================================
	always_comb begin
		logic [3:0] ev;
		logic [23:0] hl;
		ev = 4'h0;
		hl = 24'h000000;
		st_next = st_reg;
		if (ce_in) begin
			// Three-stage pin synchroniser
			st_next.sync1 = start_pin_in;
			st_next.sync2 = st_reg.sync1;
			st_next.sync3 = st_reg.sync2;
			st_next.start_lvl = start_new;
			// Pulse engine
			case (st_reg.fsm)
				PWOS_IDLE: begin
					st_next.pulse = 1'b0;
					if (start_rise) begin
						st_next.done = 1'b0;
						st_next.ovf = 1'b0;
						st_next.err = err_code;
						st_next.count = 32'h00000000;
						if (err_code == PWOS_ERR_NONE) begin
							hl = high_of(period_sel, st_reg.duty);
							st_next.fsm = PWOS_RUN;
							st_next.run = 1'b1;
							st_next.counted = (st_reg.cnten == PWOS_CNTEN_ON);
							st_next.period = period_sel;
							st_next.phase = 24'h000000;
							st_next.high_len = hl;
							st_next.pulse = (hl != 24'h000000);
							ev[PWOS_IRQ_START] = 1'b1;
						end else begin
							ev[PWOS_IRQ_ERR] = 1'b1;
						end
					end
				end
				PWOS_RUN: begin
					if (start_fall) begin
						st_next.fsm = PWOS_IDLE;
						st_next.run = 1'b0;
						st_next.done = 1'b1;
						st_next.pulse = 1'b0;
						ev[PWOS_IRQ_DONE] = 1'b1;
					end else if (COUNT_CAPABLE && st_reg.counted && st_reg.count > preset) begin
						st_next.ovf = 1'b1;
						st_next.fsm = PWOS_IDLE;
						st_next.run = 1'b0;
						st_next.done = 1'b1;
						st_next.pulse = 1'b0;
						ev[PWOS_IRQ_OVF] = 1'b1;
						ev[PWOS_IRQ_DONE] = 1'b1;
					end else if (phase_end) begin
						st_next.count = cnt_inc;
						if (st_reg.counted && cnt_inc >= preset) begin
							st_next.fsm = PWOS_IDLE;
							st_next.run = 1'b0;
							st_next.done = 1'b1;
							st_next.pulse = 1'b0;
							ev[PWOS_IRQ_DONE] = 1'b1;
						end else begin
							// Live duty taken only at a period boundary
							hl = high_of(st_reg.period, st_reg.duty);
							st_next.phase = 24'h000000;
							st_next.high_len = hl;
							st_next.pulse = (hl != 24'h000000);
						end
					end else begin
						st_next.phase = st_reg.phase + 24'h000001;
						st_next.pulse = ((st_reg.phase + 24'h000001) < st_reg.high_len);
					end
				end
				default: begin
					st_next.fsm = PWOS_IDLE;
					st_next.pulse = 1'b0;
				end
			endcase
			// Avalon slave: one wait cycle, then answer
			if ((avs_req_in.read || avs_req_in.write) && st_reg.wait_req) begin
				st_next.wait_req = 1'b0;
				st_next.rdata = avs_req_in.read ? rd_mux : 32'h00000000;
			end else begin
				st_next.wait_req = 1'b1;
			end
			if (bus_done && avs_req_in.write) begin
				if (rd_idx == PWOS_IDX_FREQ) begin
					st_next.fcode = lane_merge(st_reg.fcode, avs_req_in.writedata,
						avs_req_in.byteenable);
				end else if (rd_idx == PWOS_IDX_DUTY) begin
					st_next.duty = lane_merge(st_reg.duty, avs_req_in.writedata,
						avs_req_in.byteenable);
				end else if (rd_idx == PWOS_IDX_CNTEN) begin
					st_next.cnten = lane_merge(st_reg.cnten, avs_req_in.writedata,
						avs_req_in.byteenable);
				end else if (rd_idx == PWOS_IDX_PRE_HI) begin
					st_next.pre_hi = lane_merge(st_reg.pre_hi, avs_req_in.writedata,
						avs_req_in.byteenable);
				end else if (rd_idx == PWOS_IDX_PRE_LO) begin
					st_next.pre_lo = lane_merge(st_reg.pre_lo, avs_req_in.writedata,
						avs_req_in.byteenable);
				end else if (rd_idx == PWOS_IDX_IRQ_MASK && avs_req_in.byteenable[0]) begin
					st_next.irq_mask = avs_req_in.writedata[3:0];
				end
			end
			// Sticky events, write one to clear, a new event beats the clear
			for (int i = 0; i < PWOS_IRQ_W; i++) begin
				if (bus_done && avs_req_in.write && rd_idx == PWOS_IDX_IRQ_ST &&
					avs_req_in.byteenable[0] && avs_req_in.writedata[i]) begin
					st_next.irq_st[i] = ev[i];
				end else begin
					st_next.irq_st[i] = st_reg.irq_st[i] | ev[i];
				end
			end
			st_next.irq = |(st_next.irq_st & st_next.irq_mask);
		end
	end

	// =====================================================================
	// State register
	// =====================================================================
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_reg <= '{fsm: PWOS_IDLE, period: PERIOD_CYC0, wait_req: 1'b1,
				irq_st: PWOS_IRQ_RST, irq_mask: PWOS_IRQ_RST, fcode: PWOS_WORD_RST,
				duty: PWOS_WORD_RST, cnten: PWOS_WORD_RST, pre_hi: PWOS_WORD_RST,
				pre_lo: PWOS_WORD_RST, default: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state flops
	assign avs_rsp_out.waitrequest = st_reg.wait_req;
	assign avs_rsp_out.readdata = st_reg.rdata;
	assign pulse_pin_out = st_reg.pulse;
	assign running_out = st_reg.run;
	assign done_out = st_reg.done;
	assign overflow_out = st_reg.ovf;
	assign irq_out = st_reg.irq;

	// =====================================================================
	// Assertions
	// =====================================================================
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!resetn_in);

	property p_idle_low;
		!st_reg.run |-> !st_reg.pulse;
	endproperty
	a_idle_low: assert property (p_idle_low) else $error("pulse high while idle");

	property p_no_ovf_cont;
		!COUNT_CAPABLE |-> !st_reg.ovf;
	endproperty
	a_no_ovf_cont: assert property (p_no_ovf_cont) else $error("overflow on continuous");

	property p_start_clears;
		ce_in && start_rise |=> !st_reg.done && !st_reg.ovf;
	endproperty
	a_start_clears: assert property (p_start_clears) else $error("flags not cleared");

	property p_stop_now;
		ce_in && st_reg.run && start_fall |=> !st_reg.run && st_reg.done && !st_reg.pulse;
	endproperty
	a_stop_now: assert property (p_stop_now) else $error("start low did not stop");

	property p_count_end;
		ce_in && st_reg.run && st_reg.counted && phase_end && !start_fall &&
			!(st_reg.count > preset) && cnt_inc == preset
			|=> !st_reg.run && st_reg.done && st_reg.count == $past(cnt_inc);
	endproperty
	a_count_end: assert property (p_count_end) else $error("count end missed");

	property p_ovf_set;
		ce_in && st_reg.run && st_reg.counted && !start_fall && st_reg.count > preset
			|=> st_reg.ovf && !st_reg.run;
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("overflow not flagged");

	property p_err_freq;
		ce_in && !st_reg.run && start_rise && st_reg.fcode > PWOS_FCODE_MAX
			|=> st_reg.err == PWOS_ERR_FREQ && !st_reg.run;
	endproperty
	a_err_freq: assert property (p_err_freq) else $error("bad frequency accepted");

	property p_cont_runs;
		ce_in && st_reg.run && !st_reg.counted && !start_fall |=> st_reg.run;
	endproperty
	a_cont_runs: assert property (p_cont_runs) else $error("continuous run stopped");

	property p_flag_read;
		ce_in && avs_req_in.read && st_reg.wait_req && rd_idx == PWOS_IDX_DONE
			|=> !st_reg.wait_req && st_reg.rdata == {31'h00000000, $past(st_reg.done)};
	endproperty
	a_flag_read: assert property (p_flag_read) else $error("done flag read wrong");

	property p_period_start;
		ce_in && st_reg.run && phase_end && !start_fall && !st_reg.counted
			|=> st_reg.phase == 24'h000000 && st_reg.high_len == high_of(st_reg.period,
			$past(st_reg.duty));
	endproperty
	a_period_start: assert property (p_period_start) else $error("duty not reloaded");

	c_count_done: cover property (ce_in && st_reg.run && st_reg.counted ##1 st_reg.done);
	c_stop_start: cover property (ce_in && st_reg.run && start_fall);
	c_overflow: cover property (!st_reg.ovf ##1 st_reg.ovf);
	c_error: cover property (st_reg.err != PWOS_ERR_NONE);

endmodule
`default_nettype wire

/* rtl/unused_placeholder_never.sv */
// Empty guard file intentionally omitted
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire
